// >>> verilog/tmsl_defines.vh
/*
 * Constants for the master/slave timer link: the encodings of the master
 * output selector, the trigger source selector and the slave mode selector,
 * plus the register map of the plain software port.
 * Assumes one peripheral clock and a synchronous software register port.
 */
`ifndef TMSL_DEFINES_VH
`define TMSL_DEFINES_VH

// ---------------------------------------------------------------------------
// Master output selector encodings
// ---------------------------------------------------------------------------
`define TMSL_MOS_RESET   3'h0
`define TMSL_MOS_ENABLE  3'h1
`define TMSL_MOS_UPDATE  3'h2
`define TMSL_MOS_OC1     3'h4

// ---------------------------------------------------------------------------
// Trigger source and slave mode encodings
// ---------------------------------------------------------------------------
`define TMSL_TSS_INTERNAL_TRIGGER_ZERO    3'h0
`define TMSL_TSS_TI1     3'h4
`define TMSL_TSS_FILTERED_EXT_TRIGGER    3'h7
`define TMSL_SMS_OFF     3'h0
`define TMSL_SMS_GATED   3'h5
`define TMSL_SMS_TRIG    3'h6
`define TMSL_SMS_EXT1    3'h7

// ---------------------------------------------------------------------------
// Register offsets (word index on the plain port)
// ---------------------------------------------------------------------------
`define TMSL_REG_CTRL    4'h0
`define TMSL_REG_SMODE   4'h1
`define TMSL_REG_EVGEN   4'h2
`define TMSL_REG_STAT    4'h3
`define TMSL_REG_CNT     4'h4
`define TMSL_REG_PSC     4'h5
`define TMSL_REG_ARR     4'h6
`define TMSL_REG_CCR1    4'h7
`define TMSL_REG_OPT     4'h8

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define TMSL_CTRL_CEN    0
`define TMSL_CTRL_OC1P   1
`define TMSL_CTRL_MOS_LO 4
`define TMSL_SM_SMS_LO   0
`define TMSL_SM_TSS_LO   4
`define TMSL_SM_MSA      7
`define TMSL_SM_ETP      8
`define TMSL_SM_ETPS_LO  9
`define TMSL_SM_ETF_LO   12
`define TMSL_EG_UG       0
`define TMSL_EG_TG       1
`define TMSL_OPT_ECS_LO  0
`define TMSL_OPT_MSKEN   2

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define TMSL_RST_ARR     16'hffff
`define TMSL_RST_ZERO16  16'h0000

`endif

// >>> verilog/tmsl_timer.v
/*
 * One general-purpose timer with the master/slave link: trigger output
 * selection, slave mode controller, external trigger conditioning, channel 1
 * compare reference and capture, counter and prescaler.
 * Assumes all inputs synchronous to clk (peripheral clock), software port
 * with one-cycle strobes and read data valid in the cycle after a read.
 */
// The register offsets and the plain strobed port were decided locally.
`include "tmsl_defines.vh"
`timescale 1ns/100ps
`default_nettype none

// Contract
// RULE_01: Selector 010 emits trigger on each update
// RULE_02: Source 000 takes other timer trigger output
// RULE_03: Slave mode 111 counts trigger rising edges
// RULE_04: Selector 1xx drives compare output as trigger
// RULE_05: Selector 100 drives channel one reference
// RULE_06: Gated mode 101 counts while trigger high
// RULE_07: Gating only touches counter enable
// RULE_08: Start or gate keeps current count values
// RULE_09: Update generate resets counter and prescaler
// RULE_10: Trigger mode 110 sets enable until cleared
// RULE_11: Selector 001 drives counter enable state
// RULE_12: Source 100 takes timer input one
// RULE_13: Align bit delays enable before prescaler
// RULE_14: Input one edge starts both, flags set
// RULE_15: Software counter writes take effect
// RULE_16: Internal count clock is peripheral clock
// RULE_17: Peripheral clock also clocks input filters
// RULE_18: External trigger clock chosen by option field
// RULE_19: External trigger: polarity, edge, prescale, filter
// RULE_20: Compare pin equals reference after inversion
// RULE_21: Clock mask ANDed with other timer clock
// RULE_22: Conditioned capture input loads capture register
// RULE_23: Update trigger pulse lasts one cycle
module tmsl_timer (
	input  wire        clk,
	input  wire        rstn,
	input  wire [3:0]  addr,
	input  wire [15:0] wdata,
	input  wire        wr,
	input  wire        rd,
	output reg  [15:0] rdata_ff,
	input  wire        internal_trigger_zero,
	input  wire        timer_input_one,
	input  wire [1:0]  timer_clock_pin,
	input  wire        other_clock_pin,
	input  wire        clock_mask_in,
	output reg         trigger_output_ff,
	output reg         compare_pin_output_ff,
	output reg         masked_clock_ff,
	output reg         trigger_flag_ff
);

	// -----------------------------------------------------------------------
	// Software registers
	// -----------------------------------------------------------------------
	reg        counter_enable_bit_ff;
	reg        oc1_pol_ff;
	reg [2:0]  master_output_select_ff;
	reg [2:0]  slave_mode_select_ff;
	reg [2:0]  trigger_source_select_ff;
	reg        master_slave_align_ff;
	reg        etr_pol_ff;
	reg [1:0]  etr_psc_ff;
	reg [3:0]  etr_filt_ff;
	reg [1:0]  ext_trigger_clock_select_ff;
	reg        mask_en_ff;
	reg [15:0] cnt_ff;
	reg [15:0] psc_ff;
	reg [15:0] pdiv_ff;
	reg [15:0] arr_ff;
	reg [15:0] ccr1_ff;
	reg [15:0] cap1_ff;
	reg        update_flag_ff;

	wire wr_ctrl  = wr && (addr == `TMSL_REG_CTRL);
	wire wr_smode = wr && (addr == `TMSL_REG_SMODE);
	wire wr_evgen = wr && (addr == `TMSL_REG_EVGEN);
	wire wr_stat  = wr && (addr == `TMSL_REG_STAT);
	wire wr_cnt   = wr && (addr == `TMSL_REG_CNT);
	wire update_generate_bit = wr_evgen && wdata[`TMSL_EG_UG];
	wire soft_trig = wr_evgen && wdata[`TMSL_EG_TG];

	// -----------------------------------------------------------------------
	// External trigger conditioning
	// -----------------------------------------------------------------------
	// Option field picks the clock that feeds the external trigger
	wire ext_trigger_in = timer_clock_pin[ext_trigger_clock_select_ff[0]]; // [RULE_18]
	reg        etr_prev_ff;
	reg [2:0]  etr_pcnt_ff;
	reg        conditioned_ext_trigger_ff;
	reg [3:0]  etr_fcnt_ff;
	reg        filtered_ext_trigger_ff;
	wire       etr_pol  = ext_trigger_in ^ etr_pol_ff;
	wire       etr_edge = etr_pol && !etr_prev_ff;
	wire [2:0] etr_div  = (3'h1 << etr_psc_ff) - 3'h1;

	// Polarity, edge, prescale, then a stability filter on clk
	always @(posedge clk or negedge rstn) begin // [RULE_19] [RULE_17]
		if (!rstn) begin
			etr_prev_ff <= 1'b0;
			etr_pcnt_ff <= 3'h0;
			conditioned_ext_trigger_ff <= 1'b0;
			etr_fcnt_ff <= 4'h0;
			filtered_ext_trigger_ff <= 1'b0;
		end else begin
			etr_prev_ff <= etr_pol;
			conditioned_ext_trigger_ff <= 1'b0;
			if (etr_edge) begin
				if (etr_pcnt_ff >= etr_div) begin
					etr_pcnt_ff <= 3'h0;
					conditioned_ext_trigger_ff <= 1'b1;
				end else begin
					etr_pcnt_ff <= etr_pcnt_ff + 3'h1;
				end
			end
			if (conditioned_ext_trigger_ff == filtered_ext_trigger_ff) begin
				etr_fcnt_ff <= 4'h0;
			end else if (etr_fcnt_ff >= etr_filt_ff) begin
				etr_fcnt_ff <= 4'h0;
				filtered_ext_trigger_ff <= conditioned_ext_trigger_ff;
			end else begin
				etr_fcnt_ff <= etr_fcnt_ff + 4'h1;
			end
		end
	end

	// -----------------------------------------------------------------------
	// Trigger selection and slave mode controller
	// -----------------------------------------------------------------------
	reg trgi;
	always @* begin
		case (trigger_source_select_ff)
			`TMSL_TSS_INTERNAL_TRIGGER_ZERO: trgi = internal_trigger_zero; // [RULE_02]
			`TMSL_TSS_TI1:  trgi = timer_input_one;       // [RULE_12]
			`TMSL_TSS_FILTERED_EXT_TRIGGER: trgi = filtered_ext_trigger_ff;
			default:        trgi = 1'b0;
		endcase
	end

	reg  trgi_prev_ff;
	wire trgi_rise = (trgi && !trgi_prev_ff) || soft_trig;
	wire trgi_fall = !trgi && trgi_prev_ff;
	wire is_gated  = (slave_mode_select_ff == `TMSL_SMS_GATED);
	wire is_trig   = (slave_mode_select_ff == `TMSL_SMS_TRIG);
	wire is_ext1   = (slave_mode_select_ff == `TMSL_SMS_EXT1);

	// Gating affects only the enable; count clock stays the internal one
	wire counter_enable_signal = counter_enable_bit_ff &&
		(!is_gated || trgi); // [RULE_06] [RULE_07]

	// Align option holds the enable one cycle before the prescaler
	reg  cen_dly_ff;
	wire cen_eff = master_slave_align_ff ? cen_dly_ff
		: counter_enable_signal; // [RULE_13]

	// Prescaler input: internal clock tick, or trigger edges in mode 111
	wire prescaler_clock_in = is_ext1 ? trgi_rise : 1'b1; // [RULE_03] [RULE_16]
	wire internal_count_clock = cen_eff && prescaler_clock_in;
	wire psc_wrap = internal_count_clock && (pdiv_ff >= psc_ff);
	wire overflow = psc_wrap && (cnt_ff >= arr_ff);
	wire update_event = overflow || update_generate_bit;

	// Control register with trigger-mode set of the enable
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			counter_enable_bit_ff <= 1'b0;
			oc1_pol_ff <= 1'b0;
			master_output_select_ff <= `TMSL_MOS_RESET;
			trgi_prev_ff <= 1'b0;
			cen_dly_ff <= 1'b0;
		end else begin
			trgi_prev_ff <= trgi;
			cen_dly_ff <= counter_enable_signal;
			if (wr_ctrl) begin
				counter_enable_bit_ff <= wdata[`TMSL_CTRL_CEN];
				oc1_pol_ff <= wdata[`TMSL_CTRL_OC1P];
				master_output_select_ff <= wdata[`TMSL_CTRL_MOS_LO+:3];
			end
			if (is_trig && trgi_rise) begin
				counter_enable_bit_ff <= 1'b1; // [RULE_10] [RULE_14]
			end
		end
	end

	// Slave mode, option and compare registers
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			slave_mode_select_ff <= `TMSL_SMS_OFF;
			trigger_source_select_ff <= `TMSL_TSS_INTERNAL_TRIGGER_ZERO;
			master_slave_align_ff <= 1'b0;
			etr_pol_ff <= 1'b0;
			etr_psc_ff <= 2'h0;
			etr_filt_ff <= 4'h0;
			ext_trigger_clock_select_ff <= 2'h0;
			mask_en_ff <= 1'b0;
			psc_ff <= `TMSL_RST_ZERO16;
			arr_ff <= `TMSL_RST_ARR;
			ccr1_ff <= `TMSL_RST_ZERO16;
		end else if (wr) begin
			case (addr)
				`TMSL_REG_SMODE: begin
					slave_mode_select_ff <= wdata[`TMSL_SM_SMS_LO+:3];
					trigger_source_select_ff <= wdata[`TMSL_SM_TSS_LO+:3];
					master_slave_align_ff <= wdata[`TMSL_SM_MSA];
					etr_pol_ff <= wdata[`TMSL_SM_ETP];
					etr_psc_ff <= wdata[`TMSL_SM_ETPS_LO+:2];
					etr_filt_ff <= wdata[`TMSL_SM_ETF_LO+:4];
				end
				`TMSL_REG_PSC:  psc_ff <= wdata;
				`TMSL_REG_ARR:  arr_ff <= wdata;
				`TMSL_REG_CCR1: ccr1_ff <= wdata;
				`TMSL_REG_OPT: begin
					ext_trigger_clock_select_ff <=
						wdata[`TMSL_OPT_ECS_LO+:2];
					mask_en_ff <= wdata[`TMSL_OPT_MSKEN];
				end
				default: begin
				end
			endcase
		end
	end

	// -----------------------------------------------------------------------
	// Counter and prescaler
	// -----------------------------------------------------------------------
	// No reload on start or gate: counting resumes from held values
	always @(posedge clk or negedge rstn) begin // [RULE_08]
		if (!rstn) begin
			cnt_ff <= `TMSL_RST_ZERO16;
			pdiv_ff <= `TMSL_RST_ZERO16;
		end else if (update_generate_bit) begin
			cnt_ff <= `TMSL_RST_ZERO16; // [RULE_09]
			pdiv_ff <= `TMSL_RST_ZERO16;
		end else if (wr_cnt) begin
			cnt_ff <= wdata; // [RULE_15]
		end else if (internal_count_clock) begin
			pdiv_ff <= psc_wrap ? `TMSL_RST_ZERO16 : pdiv_ff + 16'h0001;
			if (psc_wrap) begin
				cnt_ff <= overflow ? `TMSL_RST_ZERO16 : cnt_ff + 16'h0001;
			end
		end
	end

	// -----------------------------------------------------------------------
	// Channel 1 compare reference and capture
	// -----------------------------------------------------------------------
	wire compare_reference = (cnt_ff < ccr1_ff); // active high
	wire channel_one_compare_ref = compare_reference;
	reg  ti1_prev_ff;
	wire prescaled_capture_input = timer_input_one && !ti1_prev_ff;

	// Capture on the edge-detected input, compare pin with polarity
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ti1_prev_ff <= 1'b0;
			cap1_ff <= `TMSL_RST_ZERO16;
			compare_pin_output_ff <= 1'b0;
			masked_clock_ff <= 1'b0;
		end else begin
			ti1_prev_ff <= timer_input_one;
			if (prescaled_capture_input) begin
				cap1_ff <= cnt_ff; // [RULE_22]
			end
			compare_pin_output_ff <= compare_reference ^ oc1_pol_ff; // [RULE_20]
			masked_clock_ff <= mask_en_ff ?
				(clock_mask_in && other_clock_pin) : other_clock_pin; // [RULE_21]
		end
	end

	// -----------------------------------------------------------------------
	// Master trigger output and flags
	// -----------------------------------------------------------------------
	// Update pulse is one cycle wide; enable and reference are levels
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			trigger_output_ff <= 1'b0;
			trigger_flag_ff <= 1'b0;
			update_flag_ff <= 1'b0;
		end else begin
			if (master_output_select_ff[2]) begin
				trigger_output_ff <= channel_one_compare_ref; // [RULE_04] [RULE_05]
			end else if (master_output_select_ff == `TMSL_MOS_ENABLE) begin
				trigger_output_ff <= cen_eff; // [RULE_11]
			end else if (master_output_select_ff == `TMSL_MOS_UPDATE) begin
				trigger_output_ff <= update_event; // [RULE_01] [RULE_23]
			end else begin
				trigger_output_ff <= update_generate_bit;
			end
			// Set beats a clear written in the same cycle
			if ((is_trig && trgi_rise) ||
				(is_gated && (trgi_rise || trgi_fall))) begin
				trigger_flag_ff <= 1'b1; // [RULE_14]
			end else if (wr_stat && wdata[1]) begin
				trigger_flag_ff <= 1'b0;
			end
			if (update_event) begin
				update_flag_ff <= 1'b1;
			end else if (wr_stat && wdata[0]) begin
				update_flag_ff <= 1'b0;
			end
		end
	end

	// -----------------------------------------------------------------------
	// Read port
	// -----------------------------------------------------------------------
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata_ff <= `TMSL_RST_ZERO16;
		end else if (rd) begin
			case (addr)
				`TMSL_REG_CTRL: rdata_ff <= {9'h000, master_output_select_ff,
					2'h0, oc1_pol_ff, counter_enable_bit_ff};
				`TMSL_REG_SMODE: rdata_ff <= {etr_filt_ff, 1'b0, etr_psc_ff,
					etr_pol_ff, master_slave_align_ff,
					trigger_source_select_ff, 1'b0, slave_mode_select_ff};
				`TMSL_REG_STAT: rdata_ff <= {13'h0000, cen_eff,
					trigger_flag_ff, update_flag_ff};
				`TMSL_REG_CNT:  rdata_ff <= cnt_ff;
				`TMSL_REG_PSC:  rdata_ff <= psc_ff;
				`TMSL_REG_ARR:  rdata_ff <= arr_ff;
				`TMSL_REG_CCR1: rdata_ff <= cap1_ff;
				`TMSL_REG_OPT:  rdata_ff <= {13'h0000, mask_en_ff,
					ext_trigger_clock_select_ff};
				default:        rdata_ff <= `TMSL_RST_ZERO16;
			endcase
		end else begin
			rdata_ff <= `TMSL_RST_ZERO16;
		end
	end

endmodule // tmsl_timer

`default_nettype wire

// >>> testbench/tmsl_peer_model.sv
/*
 * Behavioural model of the other timer on chip: update-style trigger
 * pulses, a held trigger level (compare reference style) and its clock pin.
 * Assumes the same peripheral clock and reset as the timer under test.
 */
`timescale 1ns/100ps
`default_nettype none
module tmsl_peer_model (
	input  wire logic       clk,
	input  wire logic       rstn,
	input  wire logic [3:0] pulse_cnt,
	input  wire logic       load,
	input  wire logic       gate,
	output var  logic       trg_ff,
	output var  logic       clk_pin_ff
);
	logic [3:0] left_ff;
	logic [1:0] ph_ff;
	// ---------------------------------------------------------------
	// Pulse train every four cycles, or a held level while gate is up
	// ---------------------------------------------------------------
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			left_ff <= 4'h0;
			ph_ff <= 2'h0;
			trg_ff <= 1'b0;
			clk_pin_ff <= 1'b0;
		end else begin
			ph_ff <= ph_ff + 2'h1;
			clk_pin_ff <= ~clk_pin_ff; // Free-running clock pin
			if (load)
				left_ff <= pulse_cnt;
			else if (ph_ff == 2'h0 && left_ff != 4'h0)
				left_ff <= left_ff - 4'h1;
			// One-cycle pulse per update, level for reference
			trg_ff <= gate | (ph_ff == 2'h0 && left_ff != 4'h0 && !load);
		end
	end
endmodule // tmsl_peer_model
`default_nettype wire

// >>> testbench/tmsl_timer_monitor.sv
/*
 * Port checker for tmsl_timer, bound to every instance.
 * Assumes one clock and the one-cycle software port strobes.
 */
`timescale 1ns/100ps
`default_nettype none
module tmsl_timer_monitor (
	input wire        clk,
	input wire        rstn,
	input wire [3:0]  addr,
	input wire [15:0] wdata,
	input wire        wr,
	input wire        rd,
	input wire [15:0] rdata_ff,
	input wire        internal_trigger_zero,
	input wire        timer_input_one,
	input wire [1:0]  timer_clock_pin,
	input wire        other_clock_pin,
	input wire        clock_mask_in,
	input wire        trigger_output_ff,
	input wire        compare_pin_output_ff,
	input wire        masked_clock_ff,
	input wire        trigger_flag_ff
);
	logic [2:0] mos_ff;
	logic       pol_ff, cen_ff, msk_ff;
	logic [1:0] cage_ff, oage_ff;
	// ---------------------------------------------------------------
	// Shadow of control and option writes, each with its settle age since the last write
	// ---------------------------------------------------------------
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			{mos_ff, pol_ff, cen_ff, msk_ff} <= 6'h0;
			{cage_ff, oage_ff} <= 4'h0;
		end else begin
			if (wr && addr == 4'h0) begin
				{mos_ff, pol_ff, cen_ff} <= {wdata[6:4], wdata[1:0]};
				cage_ff <= 2'h0;
			end else if (cage_ff != 2'h3)
				cage_ff <= cage_ff + 2'h1;
			if (wr && addr == 4'h8) begin
				msk_ff <= wdata[2];
				oage_ff <= 2'h0;
			end else if (oage_ff != 2'h3)
				oage_ff <= oage_ff + 2'h1;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	sequence s_ug_mos0;
		wr && addr == 4'h2 && wdata[0] && mos_ff == 3'h0 && cage_ff == 2'h3;
	endsequence
	AST_RD_IDLE: assert property (!rd |=> rdata_ff == 16'h0)
		else $error("read data not zero outside a read");
	AST_UNMAPPED: assert property (rd && addr > 4'h8 |=> rdata_ff == 16'h0)
		else $error("unmapped read not zero");
	AST_RST_OUT: assert property ($rose(rstn) |-> !trigger_output_ff
		&& !trigger_flag_ff && !masked_clock_ff) else $error("outputs after reset");
	AST_UPD_PULSE: assert property (mos_ff == 3'h2 && cage_ff == 2'h3 &&
		trigger_output_ff |=> !trigger_output_ff) else $error("update pulse long");
	AST_ENA_TRG: assert property (mos_ff == 3'h1 && cage_ff == 2'h3 |->
		trigger_output_ff == cen_ff) else $error("enable trigger wrong");
	AST_UG_TRG: assert property (s_ug_mos0 |-> ##[1:2] trigger_output_ff)
		else $error("no trigger after update generate");
	AST_PIN_POL: assert property (mos_ff == 3'h4 && cage_ff == 2'h3 &&
		$changed(compare_pin_output_ff) |-> ##[0:2]
		(compare_pin_output_ff ^ pol_ff) == trigger_output_ff)
		else $error("compare pin polarity wrong");
	AST_MASK: assert property (oage_ff == 2'h3 |=> masked_clock_ff ==
		($past(other_clock_pin) & ($past(clock_mask_in) | !$past(msk_ff))))
		else $error("masked clock wrong");
	AST_FLAG_HOLD: assert property (trigger_flag_ff &&
		!(wr && addr == 4'h3 && wdata[1]) |=> trigger_flag_ff)
		else $error("trigger flag lost");
endmodule // tmsl_timer_monitor
bind tmsl_timer tmsl_timer_monitor u_mon (.clk, .rstn, .addr, .wdata, .wr,
	.rd, .rdata_ff, .internal_trigger_zero, .timer_input_one, .timer_clock_pin,
	.other_clock_pin, .clock_mask_in, .trigger_output_ff,
	.compare_pin_output_ff, .masked_clock_ff, .trigger_flag_ff);
`default_nettype wire

// >>> testbench/timer_master_slave_link_tb_top.sv
/*
 * Self-checking bench for tmsl_timer with a model of the other timer.
 * Assumes a 10 MHz clock and register reads valid the cycle after rd.
 */
`timescale 1ns/100ps
`default_nettype none
module timer_master_slave_link_tb_top;
	logic clk, rstn, wr, rd, timer_input_one, clock_mask_in, peer_load, peer_gate;
	logic [3:0]  addr, peer_cnt;
	logic [15:0] wdata, d, c1;
	wire  [15:0] rdata_ff;
	wire  internal_trigger_zero, other_clock_pin, trigger_output_ff;
	wire  compare_pin_output_ff, masked_clock_ff, trigger_flag_ff;
	int   err_total = 0, n_tests = 0, e, h;
	tmsl_timer uut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata_ff(rdata_ff), .timer_input_one(timer_input_one),
		.internal_trigger_zero(internal_trigger_zero),
		.timer_clock_pin({other_clock_pin, 1'b0}),
		.other_clock_pin(other_clock_pin), .clock_mask_in(clock_mask_in),
		.trigger_output_ff(trigger_output_ff), .trigger_flag_ff(trigger_flag_ff),
		.compare_pin_output_ff(compare_pin_output_ff),
		.masked_clock_ff(masked_clock_ff));
	tmsl_peer_model u_peer (.clk(clk), .rstn(rstn), .pulse_cnt(peer_cnt),
		.load(peer_load), .gate(peer_gate), .trg_ff(internal_trigger_zero),
		.clk_pin_ff(other_clock_pin));
	// ---------------------------------------------------------------
	// Bus cycles and comparisons
	// ---------------------------------------------------------------
	task automatic wreg(input logic [3:0] a, input logic [15:0] v);
		@(posedge clk);
		{addr, wdata, wr} <= {a, v, 1'b1};
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] a, output logic [15:0] v);
		@(posedge clk);
		{addr, rd} <= {a, 1'b1};
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		v = rdata_ff;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] x);
		n_tests++;
		if (g !== x) begin
			err_total++;
			$display("BAD t=%0t got %h exp %h", $time, g, x);
		end
	endtask
	// Rising edges and high cycles of trigger (sel 0) or masked clock
	task automatic samp(input int n, input bit sel, output int re, output int hi);
		logic s, p;
		p = 1'b1;
		re = 0;
		hi = 0;
		repeat (n) begin
			@(negedge clk);
			s = sel ? masked_clock_ff : trigger_output_ff;
			hi += (s === 1'b1);
			re += (s === 1'b1 && p !== 1'b1);
			p = s;
		end
	endtask
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_regs;
		rreg(4'h0, d);
		chk(d, 16'h0000);
		rreg(4'h6, d);
		chk(d, 16'hffff);
		rreg(4'hc, d);
		chk(d, 16'h0000);
		wreg(4'h4, 16'h00e7);
		rreg(4'h4, d);
		chk(d, 16'h00e7);
		wreg(4'h2, 16'h0001);
		rreg(4'h4, d);
		chk(d, 16'h0000);
		$display("t_regs done");
	endtask
	task automatic t_upd;
		wreg(4'h6, 16'h0003);
		wreg(4'h0, 16'h0021);
		samp(40, 1'b0, e, h);
		chk(16'(h), 16'(e));
		chk(16'(e >= 9 && e <= 11), 16'h1);
		wreg(4'h0, 16'h0000);
		$display("t_upd done");
	endtask
	task automatic t_ext1;
		wreg(4'h6, 16'hffff);
		wreg(4'h1, 16'h0007);
		wreg(4'h2, 16'h0001);
		wreg(4'h0, 16'h0001);
		@(posedge clk);
		{peer_cnt, peer_load} <= {4'h5, 1'b1};
		@(posedge clk);
		peer_load <= 1'b0;
		repeat (25) @(posedge clk);
		rreg(4'h4, d);
		chk(d, 16'h0005);
		$display("t_ext1 done");
	endtask
	task automatic t_gate;
		wreg(4'h0, 16'h0000);
		wreg(4'h1, 16'h0005);
		wreg(4'h2, 16'h0001);
		wreg(4'h0, 16'h0001);
		peer_gate <= 1'b1;
		repeat (10) @(posedge clk);
		peer_gate <= 1'b0;
		repeat (4) @(posedge clk);
		rreg(4'h4, c1);
		chk(16'(c1 >= 8 && c1 <= 12), 16'h1);
		repeat (5) @(posedge clk);
		rreg(4'h4, d);
		chk(d, c1);
		peer_gate <= 1'b1;
		repeat (5) @(posedge clk);
		peer_gate <= 1'b0;
		repeat (4) @(posedge clk);
		rreg(4'h4, d);
		chk(16'(d - c1 >= 4 && d - c1 <= 6), 16'h1);
		$display("t_gate done");
	endtask
	task automatic t_trig;
		wreg(4'h0, 16'h0000);
		wreg(4'h1, 16'h0046);
		wreg(4'h2, 16'h0001);
		wreg(4'h4, 16'h0012);
		wreg(4'h3, 16'h0003);
		timer_input_one <= 1'b1;
		repeat (5) @(posedge clk);
		rreg(4'h3, d);
		chk(d & 16'h0006, 16'h0006);
		chk(16'(trigger_flag_ff), 16'h1);
		rreg(4'h4, c1);
		rreg(4'h4, d);
		chk(16'(d > c1), 16'h1);
		wreg(4'h0, 16'h0000);
		rreg(4'h4, c1);
		rreg(4'h4, d);
		chk(d, c1);
		rreg(4'h7, d);
		chk(d, 16'h0012);
		timer_input_one <= 1'b0;
		$display("t_trig done");
	endtask
	task automatic t_mos;
		wreg(4'h1, 16'h0000);
		wreg(4'h0, 16'h0011);
		repeat (4) @(negedge clk);
		chk(16'(trigger_output_ff), 16'h1);
		wreg(4'h0, 16'h0010);
		repeat (4) @(negedge clk);
		chk(16'(trigger_output_ff), 16'h0);
		wreg(4'h1, 16'h0080);
		wreg(4'h0, 16'h0011);
		repeat (2) @(negedge clk);
		chk(16'(trigger_output_ff), 16'h0);
		@(negedge clk);
		chk(16'(trigger_output_ff), 16'h1);
		wreg(4'h0, 16'h0010);
		wreg(4'h1, 16'h0000);
		wreg(4'h6, 16'h000f);
		wreg(4'h7, 16'h0008);
		wreg(4'h2, 16'h0001);
		wreg(4'h0, 16'h0041);
		samp(32, 1'b0, e, h);
		chk(16'(h >= 15 && h <= 17), 16'h1);
		wreg(4'h0, 16'h0043);
		repeat (2) @(negedge clk);
		h = 0;
		repeat (16) begin
			@(negedge clk);
			h += (compare_pin_output_ff !== trigger_output_ff);
		end
		chk(16'(h), 16'h0010);
		wreg(4'h0, 16'h0000);
		$display("t_mos done");
	endtask
	task automatic t_mask;
		wreg(4'h8, 16'h0004);
		clock_mask_in <= 1'b0;
		repeat (3) @(posedge clk);
		samp(8, 1'b1, e, h);
		chk(16'(h), 16'h0);
		@(posedge clk);
		clock_mask_in <= 1'b1;
		repeat (3) @(posedge clk);
		samp(8, 1'b1, e, h);
		chk(16'(h), 16'h4);
		$display("t_mask done");
	endtask
	// External trigger from clock pin 1 clocks the counter in mode 111
	task automatic t_etr;
		wreg(4'h8, 16'h0001);
		wreg(4'h1, 16'h0077);
		wreg(4'h2, 16'h0001);
		wreg(4'h0, 16'h0001);
		repeat (20) @(posedge clk);
		wreg(4'h0, 16'h0000);
		rreg(4'h4, d);
		chk(16'(d >= 10 && d <= 12), 16'h1);
		$display("t_etr done");
	endtask
	// ---------------------------------------------------------------
	// Clock, watchdog and main sequence
	// ---------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		#(100 * 20000);
		err_total++;
		end_of_test;
	end
	initial begin
		{rstn, wr, rd, timer_input_one, clock_mask_in, peer_load, peer_gate} = 7'h0;
		{addr, peer_cnt, wdata} = 24'h0;
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		t_regs;
		t_upd;
		t_ext1;
		t_gate;
		t_trig;
		t_mos;
		t_mask;
		t_etr;
		end_of_test;
	end
endmodule // timer_master_slave_link_tb_top
`default_nettype wire
